// ===== shared/ddr3_readout_pkg.sv
// Shared constants for the DDR3 calibration readout link and its ends
package ddr3_readout_pkg;
  // ----------------------------------------------------------------
  // Command encodings as {ras_n, cas_n, we_n} with cs_n low
  // ----------------------------------------------------------------
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_WR = 3'h4;
  localparam logic [2:0] CMD_RD = 3'h5;
  localparam logic [2:0] CMD_NOP = 3'h7;

  // ----------------------------------------------------------------
  // Mode register selection and fields
  // ----------------------------------------------------------------
  localparam logic [2:0] BA_MR0 = 3'h0;
  localparam logic [2:0] BA_MR3 = 3'h3;
  localparam int EN_BIT = 2;
  localparam int AP_BIT = 10;
  localparam int BC_BIT = 12;
  localparam int NIB_BIT = 2;
  localparam logic [1:0] BL_FIX8 = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_FIX4 = 2'h2;
  localparam logic [1:0] LOC_CAL = 2'h0;
  localparam logic [7:0] CAL_PATTERN = 8'haa;
  localparam logic [7:0] RSV_PATTERN = 8'h00;
  localparam logic [2:0] LEFT8 = 3'h7;
  localparam logic [2:0] LEFT4 = 3'h3;
  localparam logic [2:0] NIB_HI = 3'h4;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 40;
  localparam int RL_DEF = 6;
  localparam int WL_DEF = 5;
  localparam int TRP_NS = 15;
  localparam int TRP_CYC = (TRP_NS + CLK_NS - 1) / CLK_NS;
  localparam int DLLK_DEF = 512;

  // ----------------------------------------------------------------
  // Controller register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_WDATA = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0c;
  localparam logic [7:0] OFS_RDATA = 8'h10;
  localparam logic [1:0] OP_NONE = 2'h0;
  localparam logic [1:0] OP_MRS = 2'h1;
  localparam logic [1:0] OP_RD = 2'h2;
  localparam logic [1:0] OP_WR = 2'h3;
  localparam int ST_ERR = 3;
endpackage : ddr3_readout_pkg

// ===== shared/ddr_link.sv
// Command, address and data wires between controller and device
`timescale 1ns/1ns
interface ddr_link #(
  parameter int DQ_W = 8
);
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [2:0] ba;
  logic [15:0] addr;
  logic [DQ_W-1:0] ctl_dq_o;
  logic ctl_dq_oe;
  logic [DQ_W-1:0] dev_dq_o;
  logic dev_dq_oe;
  logic [DQ_W-1:0] dq;

  // Wire level from the enables; an undriven bus reads zero
  assign dq = dev_dq_oe ? dev_dq_o : (ctl_dq_oe ? ctl_dq_o : '0);

  modport device (
    input cs_n, ras_n, cas_n, we_n, ba, addr, dq,
    output dev_dq_o, dev_dq_oe
  );
  modport controller (
    output cs_n, ras_n, cas_n, we_n, ba, addr, ctl_dq_o, ctl_dq_oe,
    input dq
  );
endinterface : ddr_link

// ===== src/ddr3_readout_device.sv
// Device end: DDR3 data path with the calibration readout mode
// Contract
// - MRS to MR3 with A2 high enters mode
// - Controller precharges all banks before enabling
// - Reads in mode come from readout register
// - Only reads until MR3 A2 low exits
// - Auto precharge read acts as plain read
// - No power-down, refresh or other commands
// - Asynchronous reset still works in mode
// - Mode off: location ignored, array used
// - MR3 A[1:0] selects the readout location
// - Readout is one bit per beat
// - x8: DQ0 carries bit, others copy/zero
// - x16: lane 0 per byte carries bit
// - Controller drives column A[1:0] as zero
// - BL8: A2 low, beats zero to seven
// - Chop: A2 selects low or high nibble
// - A12 chops on the fly, fixed chop too
// - Bank bits and A10 ignored in mode
// - Same read latency as array reads
// - Controller waits for DLL lock first; code holds back only reads until lock, not the MR3 entry
// - Beat zero is LSB, seven is MSB
// - Location 00 gives 0101 pattern
// - MR3 written with BA1, BA0 high
// - MR3 reserved address bits driven zero
`timescale 1ns/1ns
module ddr3_readout_device #(
  parameter int DQ_W = 8,
  parameter int RL = ddr3_readout_pkg::RL_DEF,
  parameter int WL = ddr3_readout_pkg::WL_DEF,
  parameter bit REPLICATE = 1'b1,
  parameter int ARRAY_AW = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  ddr_link.device link,
  output logic readout_mode,
  output logic [1:0] location,
  output logic cmd_error
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (DQ_W != 8 && DQ_W != 16) begin : g_bad_w
    $error("DQ_W must be 8 or 16");
  end
  if (RL < 1 || RL > 255 || WL < 1 || WL > 255) begin : g_bad_lat
    $error("RL and WL must lie in 1..255");
  end
  if (ARRAY_AW < 1 || ARRAY_AW > 10) begin : g_bad_aw
    $error("ARRAY_AW must lie in 1..10");
  end

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_BURST = 2'b10
  } state_e;

  localparam logic [7:0] RL_M1 = 8'(RL - 1);
  localparam logic [7:0] WL_M1 = 8'(WL - 1);

  state_e st_q, st_d;
  logic [7:0] cnt_q, cnt_d;
  logic [2:0] beat_q, beat_d;
  logic [2:0] left_q, left_d;
  logic mode_q;
  logic [1:0] loc_q;
  logic [1:0] bl_q;
  logic wr_q;
  logic from_reg_q;
  logic [1:0] loc_cap_q;
  logic [ARRAY_AW-1:0] idx_q;
  logic [DQ_W-1:0] dq_q;
  logic oe_q;
  logic err_q;
  logic [DQ_W-1:0] mem [0:(8 << ARRAY_AW)-1];

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  wire sel = !link.cs_n;
  wire [2:0] op = {link.ras_n, link.cas_n, link.we_n};
  wire is_mrs = sel && op == ddr3_readout_pkg::CMD_MRS;
  wire is_rd = sel && op == ddr3_readout_pkg::CMD_RD;
  wire is_wr = sel && op == ddr3_readout_pkg::CMD_WR;
  wire is_nop = !sel || op == ddr3_readout_pkg::CMD_NOP;
  wire mr3_wr = is_mrs && link.ba == ddr3_readout_pkg::BA_MR3;
  wire mr0_wr = is_mrs && link.ba == ddr3_readout_pkg::BA_MR0;

  // Burst shape; A10 never looked at, so RDA is just a read
  wire otf = bl_q == ddr3_readout_pkg::BL_OTF;
  wire chop_fix = bl_q == ddr3_readout_pkg::BL_FIX4;
  wire chop_otf = otf && !link.addr[ddr3_readout_pkg::BC_BIT];
  wire chop = chop_fix || chop_otf;
  wire nib_hi = chop && link.addr[ddr3_readout_pkg::NIB_BIT];
  // Full burst always starts at beat zero; A[1:0] never used
  wire [2:0] start = nib_hi ? ddr3_readout_pkg::NIB_HI : 3'h0;
  wire [9:0] idx_full = {link.ba, link.addr[9:3]};
  // Writes are refused in mode rather than sent to the array
  wire wr_ok = is_wr && !mode_q;
  wire take = st_q == ST_IDLE && (is_rd || wr_ok);
  wire in_flight = st_q != ST_IDLE && (is_rd || is_wr);
  // Anything but reads, NOP and the MR3 write is illegal in mode
  wire bad_in_mode = mode_q && !is_nop && !is_rd && !mr3_wr;

  // ----------------------------------------------------------------
  // Mode registers; reset clears the mode at any time
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= 1'b0;
      loc_q <= 2'h0;
      bl_q <= ddr3_readout_pkg::BL_FIX8;
    end else begin
      if (mr3_wr) begin
        mode_q <= link.addr[ddr3_readout_pkg::EN_BIT];
        loc_q <= link.addr[1:0];
      end
      if (mr0_wr && !mode_q) begin
        bl_q <= link.addr[1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Burst sequencer: same latency path for array and register
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    beat_d = beat_q;
    left_d = left_q;
    unique case (st_q)
      ST_IDLE: begin
        if (take) begin
          st_d = ST_WAIT;
          cnt_d = is_rd ? RL_M1 : WL_M1;
          beat_d = start;
          left_d = chop ? ddr3_readout_pkg::LEFT4
                        : ddr3_readout_pkg::LEFT8;
        end
      end
      ST_WAIT: begin
        cnt_d = cnt_q - 8'h01;
        if (cnt_q == 8'h00) begin
          st_d = ST_BURST;
        end
      end
      ST_BURST: begin
        beat_d = beat_q + 3'h1;
        left_d = left_q - 3'h1;
        if (left_q == 3'h0) begin
          st_d = ST_IDLE;
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ST_IDLE;
      cnt_q <= 8'h00;
      beat_q <= 3'h0;
      left_q <= 3'h0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      beat_q <= beat_d;
      left_q <= left_d;
    end
  end

  // Command snapshot; mode is frozen per burst so a late exit is safe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_q <= 1'b0;
      from_reg_q <= 1'b0;
      loc_cap_q <= 2'h0;
      idx_q <= '0;
    end else if (take) begin
      wr_q <= is_wr;
      from_reg_q <= mode_q;
      loc_cap_q <= loc_q;
      // Bank bits only address the array, never the register
      idx_q <= idx_full[ARRAY_AW-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Readout data and lane fan-out
  // ----------------------------------------------------------------
  wire loc_cal = loc_cap_q == ddr3_readout_pkg::LOC_CAL;
  // Reserved locations keep the ordering but return a fixed zero
  wire [7:0] agent = loc_cal ? ddr3_readout_pkg::CAL_PATTERN
                             : ddr3_readout_pkg::RSV_PATTERN;
  wire ro_bit = agent[beat_d];
  wire [DQ_W-1:0] lanes;

  // Lane 0 of every byte carries the bit; others copy or idle low
  for (genvar i = 0; i < DQ_W; i++) begin : g_lane
    if (i % 8 == 0) begin : g_lead
      assign lanes[i] = ro_bit;
    end else begin : g_rest
      assign lanes[i] = REPLICATE ? ro_bit : 1'b0;
    end
  end

  wire [DQ_W-1:0] arr_word = mem[{idx_q, beat_d}];
  wire [DQ_W-1:0] rd_word = from_reg_q ? lanes : arr_word;
  wire drive = st_d == ST_BURST && !wr_q;

  // Output flops load the beat that the next cycle shows
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dq_q <= '0;
      oe_q <= 1'b0;
    end else begin
      dq_q <= drive ? rd_word : '0;
      oe_q <= drive;
    end
  end

  // Array store; only reachable with the mode off
  always_ff @(posedge pclk) begin
    if (st_q == ST_BURST && wr_q) begin
      mem[{idx_q, beat_q}] <= link.dq;
    end
  end

  // ----------------------------------------------------------------
  // Misuse flag: illegal command in mode or a read or write mid-burst
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_q <= 1'b0;
    end else begin
      err_q <= bad_in_mode || in_flight;
    end
  end

  // Status and link outputs
  assign link.dev_dq_o = dq_q;
  assign link.dev_dq_oe = oe_q;
  assign readout_mode = mode_q;
  // Location is meaningless with the mode off, so show zero
  assign location = mode_q ? loc_q : 2'h0;
  assign cmd_error = err_q;

endmodule : ddr3_readout_device

// ===== src/ddr3_readout_controller.sv
// Controller end: APB-driven command issue and readout capture
`timescale 1ns/1ns
module ddr3_readout_controller #(
  parameter int DQ_W = 8,
  parameter int RL = ddr3_readout_pkg::RL_DEF,
  parameter int WL = ddr3_readout_pkg::WL_DEF,
  parameter int TRP_CYCLES = ddr3_readout_pkg::TRP_CYC,
  parameter int DLLK_CYCLES = ddr3_readout_pkg::DLLK_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  ddr_link.controller link
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (RL < 1 || RL > 255 || WL < 1 || WL > 255) begin : g_bad_lat
    $error("RL and WL must lie in 1..255");
  end
  if (TRP_CYCLES < 1 || TRP_CYCLES > 255) begin : g_bad_trp
    $error("TRP_CYCLES must lie in 1..255");
  end
  if (DLLK_CYCLES < 1 || DLLK_CYCLES > 65535) begin : g_bad_lock
    $error("DLLK_CYCLES must lie in 1..65535");
  end

  typedef enum logic [2:0] {
    C_IDLE = 3'b000,
    C_PRE = 3'b001,
    C_TRP = 3'b010,
    C_CMD = 3'b011,
    C_LAT = 3'b100,
    C_DATA = 3'b101
  } cstate_e;

  localparam logic [7:0] RL_M1 = 8'(RL - 1);
  localparam logic [7:0] WL_M1 = 8'(WL - 1);
  localparam logic [7:0] TRP_M1 = 8'(TRP_CYCLES - 1);
  // Lock is reached after exactly DLLK_CYCLES edges from release
  localparam logic [15:0] LOCK_N = 16'(DLLK_CYCLES);

  cstate_e st_q, st_d;
  logic [7:0] cnt_q, cnt_d;
  logic [2:0] beat_q, beat_d;
  logic [2:0] last_q, last_d;
  logic [1:0] op_q, op_d;
  logic [2:0] ba_q;
  logic [15:0] a_q;
  logic [7:0] wdata_q, rdata_q;
  logic [1:0] mr0bl_q;
  logic active_q, err_q;
  logic [15:0] lock_q;
  logic [31:0] prdata_q;
  logic cs_n_q;
  logic [2:0] rcw_q;
  logic [2:0] ba_o_q;
  logic [15:0] addr_o_q;
  logic [DQ_W-1:0] dq_q;
  logic oe_q;

  // ----------------------------------------------------------------
  // APB decode; every access answers in its first access cycle
  // ----------------------------------------------------------------
  wire setup_rd = psel && !penable && !pwrite;
  wire wr_acc = psel && penable && pwrite;
  wire hit_cmd = paddr == ddr3_readout_pkg::OFS_CMD;
  wire hit_addr = paddr == ddr3_readout_pkg::OFS_ADDR;
  wire hit_wdata = paddr == ddr3_readout_pkg::OFS_WDATA;
  wire hit_stat = paddr == ddr3_readout_pkg::OFS_STAT;
  wire hit_rdata = paddr == ddr3_readout_pkg::OFS_RDATA;
  wire busy = st_q != C_IDLE;
  wire locked = lock_q == LOCK_N;
  wire [31:0] stat_word = {28'h0, err_q, locked, active_q, busy};
  wire [31:0] rd_mux = hit_addr ? {13'h0, ba_q, a_q}
                     : hit_wdata ? {24'h0, wdata_q}
                     : hit_stat ? stat_word
                     : hit_rdata ? {24'h0, rdata_q} : 32'h0;

  // ----------------------------------------------------------------
  // Order check: refused orders only raise the sticky error
  // ----------------------------------------------------------------
  wire [1:0] op_w = pwdata[1:0];
  wire op_go = wr_acc && hit_cmd;
  wire to_mr3 = ba_q == ddr3_readout_pkg::BA_MR3;
  wire to_mr0 = ba_q == ddr3_readout_pkg::BA_MR0;
  wire en_bit = a_q[ddr3_readout_pkg::EN_BIT];
  wire is_mrs_w = op_w == ddr3_readout_pkg::OP_MRS;
  wire is_rd_w = op_w == ddr3_readout_pkg::OP_RD;
  wire exit_ok = is_mrs_w && to_mr3 && !en_bit;
  wire no_op = op_w == ddr3_readout_pkg::OP_NONE;
  wire stray = active_q && !is_rd_w && !exit_ok;
  wire unlocked = is_rd_w && !locked;
  wire refuse = busy || no_op || stray || unlocked;
  wire go = op_go && !refuse;
  wire enter = go && is_mrs_w && to_mr3 && en_bit;
  wire err_clr = wr_acc && hit_stat && pwdata[ddr3_readout_pkg::ST_ERR];

  // Burst shape as the device will see it
  wire bl_otf = mr0bl_q == ddr3_readout_pkg::BL_OTF;
  wire bc_fix = mr0bl_q == ddr3_readout_pkg::BL_FIX4;
  wire bc4 = bc_fix || (bl_otf && !a_q[ddr3_readout_pkg::BC_BIT]);
  wire a2 = bc4 && a_q[ddr3_readout_pkg::NIB_BIT];
  // Reads in mode force A[1:0] to zero and A2 low for full bursts
  wire [15:0] rd_addr = active_q ? {a_q[15:3], a2, 2'b00} : a_q;
  // Reserved MR3 bits go out as zero
  wire [15:0] mrs_addr = to_mr3 ? {13'h0, a_q[2:0]} : a_q;
  wire op_is_mrs = op_d == ddr3_readout_pkg::OP_MRS;
  wire op_is_rd = op_d == ddr3_readout_pkg::OP_RD;
  wire [2:0] cmd_rcw = op_is_mrs ? ddr3_readout_pkg::CMD_MRS
                     : op_is_rd ? ddr3_readout_pkg::CMD_RD
                     : ddr3_readout_pkg::CMD_WR;
  wire [15:0] cmd_addr = op_is_mrs ? mrs_addr
                       : op_is_rd ? rd_addr : a_q;
  wire [15:0] pre_addr = 16'(1) << ddr3_readout_pkg::AP_BIT;

  // ----------------------------------------------------------------
  // Sequencer: precharge-all and wait before entering the mode
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    beat_d = beat_q;
    last_d = last_q;
    op_d = op_q;
    unique case (st_q)
      C_IDLE: begin
        if (go) begin
          op_d = op_w;
          cnt_d = TRP_M1;
          st_d = enter ? C_PRE : C_CMD;
        end
      end
      C_PRE: begin
        st_d = C_TRP;
      end
      C_TRP: begin
        cnt_d = cnt_q - 8'h01;
        if (cnt_q == 8'h00) begin
          st_d = C_CMD;
        end
      end
      C_CMD: begin
        st_d = op_is_mrs ? C_IDLE : C_LAT;
        cnt_d = op_is_rd ? RL_M1 : WL_M1;
        beat_d = 3'h0;
        last_d = bc4 ? ddr3_readout_pkg::LEFT4 : ddr3_readout_pkg::LEFT8;
      end
      C_LAT: begin
        cnt_d = cnt_q - 8'h01;
        if (cnt_q == 8'h00) begin
          st_d = C_DATA;
        end
      end
      C_DATA: begin
        beat_d = beat_q + 3'h1;
        if (beat_q == last_q) begin
          st_d = C_IDLE;
        end
      end
      default: begin
        st_d = C_IDLE;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= C_IDLE;
      cnt_q <= 8'h00;
      beat_q <= 3'h0;
      last_q <= 3'h0;
      op_q <= ddr3_readout_pkg::OP_NONE;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      beat_q <= beat_d;
      last_q <= last_d;
      op_q <= op_d;
    end
  end

  // Software registers and tracked mode state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ba_q <= 3'h0;
      a_q <= 16'h0;
      wdata_q <= 8'h00;
      mr0bl_q <= ddr3_readout_pkg::BL_FIX8;
      active_q <= 1'b0;
      err_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      if (wr_acc && hit_addr) begin
        ba_q <= pwdata[18:16];
        a_q <= pwdata[15:0];
      end
      if (wr_acc && hit_wdata) begin
        wdata_q <= pwdata[7:0];
      end
      if (go && is_mrs_w && to_mr0) begin
        mr0bl_q <= a_q[1:0];
      end
      if (go && is_mrs_w && to_mr3) begin
        active_q <= en_bit;
      end
      // A refusal in the clearing cycle still sets the flag
      err_q <= (op_go && refuse) || (err_q && !err_clr);
      if (setup_rd) begin
        prdata_q <= rd_mux;
      end
    end
  end

  // DLL lock wait from reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_q <= 16'h0;
    end else if (!locked) begin
      lock_q <= lock_q + 16'h1;
    end
  end

  // Readout capture: bit of lane 0 per beat, beat 0 in the LSB
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 8'h00;
    end else if (st_q == C_DATA && op_q == ddr3_readout_pkg::OP_RD) begin
      rdata_q[beat_q] <= link.dq[0];
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers, loaded for the cycle about to start
  // ----------------------------------------------------------------
  wire wr_beat = st_d == C_DATA && op_d == ddr3_readout_pkg::OP_WR;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_n_q <= 1'b1;
      rcw_q <= ddr3_readout_pkg::CMD_NOP;
      ba_o_q <= 3'h0;
      addr_o_q <= 16'h0;
      dq_q <= '0;
      oe_q <= 1'b0;
    end else begin
      cs_n_q <= !(st_d == C_PRE || st_d == C_CMD);
      rcw_q <= st_d == C_PRE ? ddr3_readout_pkg::CMD_PRE
             : st_d == C_CMD ? cmd_rcw : ddr3_readout_pkg::CMD_NOP;
      // MR3 writes carry BA 011 straight from the address register
      ba_o_q <= st_d == C_CMD ? ba_q : 3'h0;
      addr_o_q <= st_d == C_PRE ? pre_addr
                : st_d == C_CMD ? cmd_addr : 16'h0;
      dq_q <= wr_beat ? {DQ_W{wdata_q[beat_d]}} : '0;
      oe_q <= wr_beat;
    end
  end

  assign link.cs_n = cs_n_q;
  assign {link.ras_n, link.cas_n, link.we_n} = rcw_q;
  assign link.ba = ba_o_q;
  assign link.addr = addr_o_q;
  assign link.ctl_dq_o = dq_q;
  assign link.ctl_dq_oe = oe_q;
  assign prdata = prdata_q;
  assign pready = penable;
  assign pslverr = 1'b0;

endmodule : ddr3_readout_controller

// ===== sim/ddr3_readout_checker.sv
// Link checker for the calibration readout mode
`timescale 1ns/1ns
module ddr3_readout_checker #(
  parameter int DQ_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [2:0] ba,
  input wire logic [15:0] addr,
  input wire logic dev_dq_oe,
  input wire logic [DQ_W-1:0] dq,
  input wire logic cmd_error
);
  // ----------------------------------------
  // Command decode, deselect counts as idle
  // ----------------------------------------
  logic mode_q, loc0_q;
  logic [1:0] bl_q;
  logic [3:0] beat_q;
  wire [2:0] cmd = cs_n ? 3'h7 : {ras_n, cas_n, we_n};
  wire mrs = cmd == 3'h0;
  wire mr3 = mrs && ba == 3'h3;
  wire pre_all = cmd == 3'h2 && addr[10];
  wire rd = cmd == 3'h5 && !dev_dq_oe;
  wire chop = bl_q == 2'h2 || bl_q == 2'h1 && !addr[12];
  // Own copy of mode, location and length, so no design state is trusted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= 1'b0;
      loc0_q <= 1'b1;
      bl_q <= 2'h0;
      beat_q <= 4'h0;
    end else begin
      if (mr3) mode_q <= addr[2];
      if (mr3) loc0_q <= addr[1:0] == 2'h0;
      if (mrs && ba == 3'h0) bl_q <= addr[1:0];
      beat_q <= dev_dq_oe ? beat_q + 4'h1 : 4'h0;
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_RD_LATENCY: assert property (
    rd |-> ##1 !dev_dq_oe [*6] ##1 dev_dq_oe) else $error("read latency");
  AST_BURST_8: assert property (
    rd && !chop |-> ##7 dev_dq_oe [*8] ##1 !dev_dq_oe) else $error("bl8");
  AST_BURST_4: assert property (
    rd && chop |-> ##7 dev_dq_oe [*4] ##1 !dev_dq_oe) else $error("bc4");
  AST_PATTERN: assert property (
    mode_q && dev_dq_oe |-> dq[0] == (loc0_q && beat_q[0]))
    else $error("readout bit");
  AST_LANES: assert property (
    mode_q && dev_dq_oe |-> (dq & ~{DQ_W{dq[0]}}) == '0)
    else $error("lane copy");
  AST_MODE_CMDS: assert property (
    mode_q |-> cmd == 3'h5 || cmd == 3'h7 || mr3) else $error("cmd in mode");
  AST_RD_ADDR: assert property (
    rd && mode_q |-> addr[1:0] == 2'h0 && (chop || !addr[2]))
    else $error("read address");
  AST_MR3_RSVD: assert property (
    mrs && ba[1:0] == 2'h3 |-> !ba[2] && addr[15:3] == 13'h0)
    else $error("mr3 reserved bits");
  AST_PRE_FIRST: assert property (
    mr3 && addr[2] && !mode_q |-> $past(pre_all, 2)) else $error("no pre");
  AST_RESET_IDLE: assert property (
    $rose(presetn) |-> cs_n && !dev_dq_oe) else $error("reset idle");
  // A well-behaved controller never makes the device flag misuse
  AST_NO_MISUSE: assert property (
    !cmd_error) else $error("device flagged a command");
endmodule : ddr3_readout_checker

// ===== sim/ddr3_readout_register_mode_tb.sv
// Bench joining controller and device over the link
`timescale 1ns/1ns
module ddr3_readout_register_mode_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, mode, misuse;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [1:0] loc;
  logic [31:0] ra [4] = '{32'h1000, 32'h71400, 32'h0, 32'h4};
  int errors, checked;
  ddr_link #(.DQ_W(8)) ddr_link_i ();
  ddr3_readout_device ddr3_readout_device_i (.pclk(pclk), .presetn(presetn),
    .link(ddr_link_i.device), .readout_mode(mode), .location(loc),
    .cmd_error(misuse));
  ddr3_readout_controller #(.DLLK_CYCLES(4)) ddr3_readout_controller_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(), .link(ddr_link_i.controller));
  ddr3_readout_checker #(.DQ_W(8)) ddr3_readout_checker_i (.pclk(pclk),
    .presetn(presetn), .cs_n(ddr_link_i.cs_n), .ras_n(ddr_link_i.ras_n),
    .cas_n(ddr_link_i.cas_n), .we_n(ddr_link_i.we_n), .ba(ddr_link_i.ba),
    .addr(ddr_link_i.addr), .dev_dq_oe(ddr_link_i.dev_dq_oe),
    .dq(ddr_link_i.dq), .cmd_error(misuse));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic stop_test;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: %h not %h", $time, seen, exp);
    end
  endtask : chk
  // One APB transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 99);
    rv = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 99) begin
      errors++;
      stop_test();
    end
    @(posedge pclk);
  endtask : apb
  // Issue a link operation and poll busy, bounded
  task automatic op(input logic [1:0] o, input logic [31:0] a);
    int n;
    apb(1'b1, 8'h04, a);
    apb(1'b1, 8'h00, {30'h0, o});
    n = 0;
    do begin
      apb(1'b0, 8'h0c, 32'h0);
      n++;
    end while (rv[0] !== 1'b0 && n < 99);
    if (n >= 99) begin
      errors++;
      stop_test();
    end
  endtask : op
  task automatic rdx(input logic [31:0] a, input logic [31:0] m);
    op(ddr3_readout_pkg::OP_RD, a);
    apb(1'b0, 8'h10, 32'h0);
    rv = rv & m;
  endtask : rdx
  // ----------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    stop_test();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    errors = 0;
    checked = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h20, 32'h0);
    chk(rv, 32'h0); // unmapped place reads zero
    op(ddr3_readout_pkg::OP_MRS, 32'h1);
    op(ddr3_readout_pkg::OP_MRS, 32'h30001);
    apb(1'b1, 8'h08, 32'h3c);
    op(ddr3_readout_pkg::OP_WR, 32'h1000);
    rdx(32'h1000, 32'hff);
    chk(rv, 32'h3c);
    op(ddr3_readout_pkg::OP_MRS, 32'h30004);
    chk({mode, loc}, 3'h4);
    foreach (ra[i]) begin
      rdx(ra[i], 32'h0f);
      chk(rv, 32'h0a);
    end
    apb(1'b1, 8'h00, 32'h3);
    apb(1'b0, 8'h0c, 32'h0);
    chk(rv, 32'he);
    apb(1'b1, 8'h0c, 32'h8);
    apb(1'b0, 8'h0c, 32'h0);
    chk(rv, 32'h6);
    op(ddr3_readout_pkg::OP_MRS, 32'h30000);
    rdx(32'h1000, 32'hff);
    chk(rv, 32'h3c);
    op(ddr3_readout_pkg::OP_MRS, 32'h30005);
    chk({mode, loc}, 3'h5);
    rdx(32'h1000, 32'hff);
    chk(rv, 32'h0);
    // Fixed chop from MR0, upper nibble of the calibration pattern
    op(ddr3_readout_pkg::OP_MRS, 32'h30000);
    op(ddr3_readout_pkg::OP_MRS, 32'h2);
    op(ddr3_readout_pkg::OP_MRS, 32'h30004);
    rdx(32'h4, 32'h0f);
    chk(rv, 32'h0a);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({mode, loc}, 3'h0);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    stop_test();
  end
endmodule : ddr3_readout_register_mode_tb
